// ### hw/pbf_pkg.sv
// Package: constants and types for the pseudobinary C/D report framer
package pbf_pkg;
  // ---------------------------------------------------------------
  // Printable characters and the delete code
  // ---------------------------------------------------------------
  localparam logic [7:0] CH_TAG_C  = 8'h43;
  localparam logic [7:0] CH_TAG_D  = 8'h44;
  localparam logic [7:0] CH_ZERO   = 8'h30;
  localparam logic [7:0] CH_PLUS   = 8'h2B;
  localparam logic [7:0] CH_PERIOD = 8'h2E;
  localparam logic [7:0] CH_SLASH  = 8'h2F;
  localparam logic [7:0] DIG_OFS   = 8'h40;
  localparam logic [7:0] CH_DEL    = 8'h7F;
  localparam logic [7:0] CH_DEL_SUB = 8'h3F;

  // ---------------------------------------------------------------
  // Cause codes and field sizes
  // ---------------------------------------------------------------
  localparam logic [2:0] CAUSE_MIN   = 3'h1;
  localparam logic [2:0] CAUSE_MAX_C = 3'h3;
  localparam logic [2:0] CAUSE_MAX_D = 3'h4;
  localparam logic [1:0] NDIG_1 = 2'h1;
  localparam logic [1:0] NDIG_2 = 2'h2;
  localparam logic [1:0] NDIG_3 = 2'h3;
  localparam logic [2:0] LAST_STAMP_DIG = 3'h3;
  localparam logic [2:0] LAST_MFLD_DIG  = 3'h5;
  localparam logic [2:0] LAST_RD_DIG    = 3'h2;
  localparam logic [11:0] D_HDR_BYTES   = 12'h006;
  localparam logic [11:0] RD_BYTES      = 12'h003;

  // ---------------------------------------------------------------
  // Saturation limits per digit count
  // ---------------------------------------------------------------
  localparam logic signed [31:0] LIM1_HI = 32'sh0000001F;
  localparam logic signed [31:0] LIM1_LO = -32'sh00000020;
  localparam logic signed [31:0] LIM2_HI = 32'sh000007FF;
  localparam logic signed [31:0] LIM2_LO = -32'sh00000800;
  localparam logic signed [31:0] LIM3_HI = 32'sh0001FFFF;
  localparam logic signed [31:0] LIM3_LO = -32'sh00020000;

  // ---------------------------------------------------------------
  // Decimal scale factors
  // ---------------------------------------------------------------
  localparam logic [10:0] POW10_0 = 11'h001;
  localparam logic [10:0] POW10_1 = 11'h00A;
  localparam logic [10:0] POW10_2 = 11'h064;
  localparam logic [10:0] POW10_3 = 11'h3E8;

  typedef enum logic [3:0] {
    S_IDLE, S_TAG, S_CAUSE, S_STAMP, S_MWAIT, S_PLUS, S_SEQ, S_MFLD,
    S_RWAIT, S_RDIG, S_PERIOD, S_BATT, S_FLUSH
  } pbf_state_e;
endpackage

// ### hw/pbf_digit_enc.sv
// Module: saturating 6-bit printable digit encoder
`timescale 1ns/100ps
module pbf_digit_enc (
  input  wire logic signed [31:0] val_i,
  input  wire logic [1:0]         ndig_i,
  input  wire logic [1:0]         idx_i,
  output logic [7:0]              byte_o,
  output logic                    sat_o
);
  // ---------------------------------------------------------------
  // Clamp to field range
  // ---------------------------------------------------------------
  logic signed [31:0] hi;
  logic signed [31:0] lo;
  logic signed [31:0] clip;
  logic [1:0]         pos;
  logic [5:0]         dig;
  logic [7:0]         raw;

  assign hi = (ndig_i == pbf_pkg::NDIG_1) ? pbf_pkg::LIM1_HI :
              (ndig_i == pbf_pkg::NDIG_2) ? pbf_pkg::LIM2_HI : pbf_pkg::LIM3_HI;
  assign lo = (ndig_i == pbf_pkg::NDIG_1) ? pbf_pkg::LIM1_LO :
              (ndig_i == pbf_pkg::NDIG_2) ? pbf_pkg::LIM2_LO : pbf_pkg::LIM3_LO;
  // Clamp, never wrap into a different value
  assign clip  = (val_i > hi) ? hi : (val_i < lo) ? lo : val_i;
  assign sat_o = (val_i > hi) || (val_i < lo);

  // ---------------------------------------------------------------
  // Digit select, most significant first
  // ---------------------------------------------------------------
  assign pos = ndig_i - 2'h1 - idx_i;
  assign dig = (pos == 2'h0) ? clip[5:0] :
               (pos == 2'h1) ? clip[11:6] : clip[17:12];
  assign raw    = {2'h0, dig} + pbf_pkg::DIG_OFS;
  assign byte_o = (raw == pbf_pkg::CH_DEL) ? pbf_pkg::CH_DEL_SUB : raw;
endmodule // pbf_digit_enc

// ### hw/pbf_cd_framer.sv
// Module: pseudobinary C/D telemetry report framer
// Notes on behaviour
// - C report starts with letter C.
// - Second byte is cause digit 1-3.
// - Each C measurement starts with plus.
// - Then one-digit encoded sequence number.
// - Then two-digit newest-reading day.
// - Then two-digit newest-reading minute.
// - Then two-digit reading interval.
// - Readings three digits each, newest first.
// - Block repeats for every selected measurement.
// - Period byte ends C measurement data.
// - One-digit battery byte ends both types.
// - D report starts with letter D.
// - D cause also allows 4, retransmission.
// - D: two-digit scheduled day after cause.
// - D is B length plus four.
// - D readings scaled by ten to shift.
// - Missing or bad reading sends three slashes.
// - Two's complement 6-bit digits, MS first.
// - Digit plus 64; 127 becomes 63.
`timescale 1ns/100ps
module pbf_cd_framer #(
  parameter int RD_W = 18
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   ce_i,
  input  wire logic                   start_i,
  input  wire logic                   fmt_d_i,
  input  wire logic [2:0]             transmission_cause_code_i,
  input  wire logic signed [7:0]      batt_i,
  input  wire logic [8:0]             sched_day_i,
  input  wire logic [10:0]            sched_min_i,
  input  wire logic [1:0]             decimal_shift_count_i,
  input  wire logic                   meas_valid_i,
  input  wire logic [5:0]             meas_seq_i,
  input  wire logic [8:0]             meas_day_i,
  input  wire logic [10:0]            meas_min_i,
  input  wire logic [15:0]            meas_interval_i,
  input  wire logic                   meas_last_i,
  input  wire logic                   rd_valid_i,
  input  wire logic signed [RD_W-1:0] rd_value_i,
  input  wire logic                   rd_bad_i,
  input  wire logic                   rd_last_i,
  input  wire logic                   tx_ready_i,
  output logic                        start_ready_o,
  output logic                        meas_ready_o,
  output logic                        rd_ready_o,
  output logic                        tx_valid_o,
  output logic [7:0]                  tx_data_o,
  output logic                        done_o,
  output logic                        cause_err_o,
  output logic                        sat_o
);
  // Reading scaled by up to a thousand must fit the 32-bit encoder value
  if (RD_W < 7 || RD_W > 20) begin : g_bad_rd_w
    $error("RD_W must lie in 7..20");
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  pbf_pkg::pbf_state_e st_q, st_d;
  logic [2:0]  dig_q, dig_d;
  logic        fmt_d_q, fmt_d_d;
  logic [2:0]  cause_q, cause_d;
  logic signed [7:0] batt_q, batt_d;
  logic [8:0]  sday_q, sday_d;
  logic [10:0] smin_q, smin_d;
  logic [1:0]  shift_q, shift_d;
  logic [5:0]  seq_q, seq_d;
  logic [8:0]  mday_q, mday_d;
  logic [10:0] mmin_q, mmin_d;
  logic [15:0] mint_q, mint_d;
  logic        mlast_q, mlast_d;
  logic signed [31:0] rval_q, rval_d;
  logic        bad_q, bad_d;
  logic        rlast_q, rlast_d;
  logic        srdy_q, srdy_d, mrdy_q, mrdy_d, rrdy_q, rrdy_d;
  logic        txv_q, txv_d;
  logic [7:0]  txd_q, txd_d;
  logic        done_q, done_d, err_q, err_d, sat_q, sat_d;
  logic [11:0] pos_q, pos_d;
  logic [7:0]  rdcnt_q, rdcnt_d;
  logic        isbatt_q, isbatt_d;

  // ---------------------------------------------------------------
  // Decode and selection
  // ---------------------------------------------------------------
  wire slot_free = !txv_q || tx_ready_i;
  wire emit_st = (st_q == pbf_pkg::S_TAG)   || (st_q == pbf_pkg::S_CAUSE) ||
                 (st_q == pbf_pkg::S_STAMP) || (st_q == pbf_pkg::S_PLUS)  ||
                 (st_q == pbf_pkg::S_SEQ)   || (st_q == pbf_pkg::S_MFLD)  ||
                 (st_q == pbf_pkg::S_RDIG)  || (st_q == pbf_pkg::S_PERIOD) ||
                 (st_q == pbf_pkg::S_BATT);
  wire emit = slot_free && emit_st;
  wire [2:0] cause_max = fmt_d_i ? pbf_pkg::CAUSE_MAX_D : pbf_pkg::CAUSE_MAX_C;
  wire cause_ok = (transmission_cause_code_i >= pbf_pkg::CAUSE_MIN) &&
                  (transmission_cause_code_i <= cause_max);
  wire start_take = start_i && srdy_q;
  wire meas_take  = meas_valid_i && mrdy_q;
  wire rd_take    = rd_valid_i && rrdy_q;
  wire tx_acc     = txv_q && tx_ready_i;

  // Scale only in D; C readings pass unscaled
  wire [10:0] pow10 = !fmt_d_q ? pbf_pkg::POW10_0 :
                      (shift_q == 2'h0) ? pbf_pkg::POW10_0 :
                      (shift_q == 2'h1) ? pbf_pkg::POW10_1 :
                      (shift_q == 2'h2) ? pbf_pkg::POW10_2 : pbf_pkg::POW10_3;
  wire signed [RD_W+11:0] scaled = rd_value_i * $signed({1'b0, pow10});
  wire signed [31:0] scaled32 = 32'(scaled);

  wire [1:0] fsel = dig_q[2:1];
  wire signed [31:0] stamp_val = (dig_q < 3'h2) ? 32'(sday_q) : 32'(smin_q);
  wire signed [31:0] mfld_val  = (fsel == 2'h0) ? 32'(mday_q) :
                                 (fsel == 2'h1) ? 32'(mmin_q) : 32'(mint_q);
  wire signed [31:0] enc_val =
      (st_q == pbf_pkg::S_SEQ)   ? 32'(seq_q) :
      (st_q == pbf_pkg::S_STAMP) ? stamp_val :
      (st_q == pbf_pkg::S_MFLD)  ? mfld_val :
      (st_q == pbf_pkg::S_RDIG)  ? rval_q : 32'(batt_q);
  wire [1:0] enc_ndig = (st_q == pbf_pkg::S_RDIG) ? pbf_pkg::NDIG_3 :
                        ((st_q == pbf_pkg::S_SEQ) || (st_q == pbf_pkg::S_BATT)) ?
                        pbf_pkg::NDIG_1 : pbf_pkg::NDIG_2;
  wire [1:0] enc_idx = (st_q == pbf_pkg::S_RDIG) ? dig_q[1:0] :
                       ((st_q == pbf_pkg::S_SEQ) || (st_q == pbf_pkg::S_BATT)) ?
                       2'h0 : {1'b0, dig_q[0]};
  logic [7:0] enc_byte;
  logic       enc_sat;

  pbf_digit_enc u_enc (
    .val_i  (enc_val),
    .ndig_i (enc_ndig),
    .idx_i  (enc_idx),
    .byte_o (enc_byte),
    .sat_o  (enc_sat)
  );

  wire rd_slash = (st_q == pbf_pkg::S_RDIG) && bad_q;
  wire [7:0] next_byte =
      (st_q == pbf_pkg::S_TAG)    ? (fmt_d_q ? pbf_pkg::CH_TAG_D : pbf_pkg::CH_TAG_C) :
      (st_q == pbf_pkg::S_CAUSE)  ? pbf_pkg::CH_ZERO + {5'h0, cause_q} :
      (st_q == pbf_pkg::S_PLUS)   ? pbf_pkg::CH_PLUS :
      (st_q == pbf_pkg::S_PERIOD) ? pbf_pkg::CH_PERIOD :
      rd_slash                    ? pbf_pkg::CH_SLASH : enc_byte;
  wire enc_used = emit_st && (st_q != pbf_pkg::S_TAG) && (st_q != pbf_pkg::S_CAUSE) &&
                  (st_q != pbf_pkg::S_PLUS) && (st_q != pbf_pkg::S_PERIOD) && !rd_slash;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_d = st_q;   dig_d = dig_q;   fmt_d_d = fmt_d_q; cause_d = cause_q;
    batt_d = batt_q; sday_d = sday_q; smin_d = smin_q; shift_d = shift_q;
    seq_d = seq_q; mday_d = mday_q; mmin_d = mmin_q; mint_d = mint_q;
    mlast_d = mlast_q; rval_d = rval_q; bad_d = bad_q; rlast_d = rlast_q;
    srdy_d = srdy_q; mrdy_d = mrdy_q; rrdy_d = rrdy_q;
    txv_d = txv_q && !tx_ready_i;
    txd_d = txd_q;
    done_d = 1'b0; err_d = 1'b0;
    sat_d = emit && enc_used && enc_sat;
    pos_d = tx_acc ? pos_q + 12'h001 : pos_q;
    rdcnt_d = rd_take ? rdcnt_q + 8'h01 : rdcnt_q;
    isbatt_d = isbatt_q;
    if (emit) begin
      txv_d = 1'b1;
      txd_d = next_byte;
      isbatt_d = (st_q == pbf_pkg::S_BATT);
    end
    case (st_q)
      pbf_pkg::S_IDLE: begin
        srdy_d = 1'b1;
        if (start_take && !cause_ok) begin
          err_d = 1'b1;
        end else if (start_take) begin
          srdy_d = 1'b0; fmt_d_d = fmt_d_i; cause_d = transmission_cause_code_i;
          batt_d = batt_i; sday_d = sched_day_i; smin_d = sched_min_i;
          shift_d = decimal_shift_count_i; pos_d = 12'h000; rdcnt_d = 8'h00;
          st_d = pbf_pkg::S_TAG;
        end
      end
      pbf_pkg::S_TAG: if (slot_free) st_d = pbf_pkg::S_CAUSE;
      pbf_pkg::S_CAUSE: if (slot_free) begin
        dig_d = 3'h0;
        st_d = fmt_d_q ? pbf_pkg::S_STAMP : pbf_pkg::S_MWAIT;
        mrdy_d = !fmt_d_q;
      end
      pbf_pkg::S_STAMP: if (slot_free) begin
        dig_d = dig_q + 3'h1;
        if (dig_q == pbf_pkg::LAST_STAMP_DIG) begin
          dig_d = 3'h0; rrdy_d = 1'b1; st_d = pbf_pkg::S_RWAIT;
        end
      end
      pbf_pkg::S_MWAIT: if (meas_take) begin
        mrdy_d = 1'b0; seq_d = meas_seq_i; mday_d = meas_day_i; mmin_d = meas_min_i;
        mint_d = meas_interval_i; mlast_d = meas_last_i; st_d = pbf_pkg::S_PLUS;
      end
      pbf_pkg::S_PLUS: if (slot_free) st_d = pbf_pkg::S_SEQ;
      pbf_pkg::S_SEQ: if (slot_free) begin
        dig_d = 3'h0; st_d = pbf_pkg::S_MFLD;
      end
      pbf_pkg::S_MFLD: if (slot_free) begin
        dig_d = dig_q + 3'h1;
        if (dig_q == pbf_pkg::LAST_MFLD_DIG) begin
          dig_d = 3'h0; rrdy_d = 1'b1; st_d = pbf_pkg::S_RWAIT;
        end
      end
      pbf_pkg::S_RWAIT: if (rd_take) begin
        rrdy_d = 1'b0; rval_d = scaled32; bad_d = rd_bad_i; rlast_d = rd_last_i;
        dig_d = 3'h0; st_d = pbf_pkg::S_RDIG;
      end
      pbf_pkg::S_RDIG: if (slot_free) begin
        dig_d = dig_q + 3'h1;
        if (dig_q == pbf_pkg::LAST_RD_DIG) begin
          dig_d = 3'h0;
          if (!rlast_q) begin
            rrdy_d = 1'b1; st_d = pbf_pkg::S_RWAIT;
          end else if (fmt_d_q) begin
            st_d = pbf_pkg::S_BATT;
          end else if (mlast_q) begin
            st_d = pbf_pkg::S_PERIOD;
          end else begin
            mrdy_d = 1'b1; st_d = pbf_pkg::S_MWAIT;
          end
        end
      end
      pbf_pkg::S_PERIOD: if (slot_free) st_d = pbf_pkg::S_BATT;
      pbf_pkg::S_BATT: if (slot_free) st_d = pbf_pkg::S_FLUSH;
      pbf_pkg::S_FLUSH: if (slot_free) begin
        done_d = 1'b1; st_d = pbf_pkg::S_IDLE;
      end
      default: st_d = pbf_pkg::S_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // Registers; clock enable freezes everything
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_q <= pbf_pkg::S_IDLE; dig_q <= 3'h0; fmt_d_q <= 1'b0; cause_q <= 3'h0;
      batt_q <= 8'sh00; sday_q <= 9'h000; smin_q <= 11'h000; shift_q <= 2'h0;
      seq_q <= 6'h00; mday_q <= 9'h000; mmin_q <= 11'h000; mint_q <= 16'h0000;
      mlast_q <= 1'b0; rval_q <= 32'sh00000000; bad_q <= 1'b0; rlast_q <= 1'b0;
      srdy_q <= 1'b0; mrdy_q <= 1'b0; rrdy_q <= 1'b0; txv_q <= 1'b0; txd_q <= 8'h00;
      done_q <= 1'b0; err_q <= 1'b0; sat_q <= 1'b0; pos_q <= 12'h000;
      rdcnt_q <= 8'h00; isbatt_q <= 1'b0;
    end else if (ce_i) begin
      st_q <= st_d; dig_q <= dig_d; fmt_d_q <= fmt_d_d; cause_q <= cause_d;
      batt_q <= batt_d; sday_q <= sday_d; smin_q <= smin_d; shift_q <= shift_d;
      seq_q <= seq_d; mday_q <= mday_d; mmin_q <= mmin_d; mint_q <= mint_d;
      mlast_q <= mlast_d; rval_q <= rval_d; bad_q <= bad_d; rlast_q <= rlast_d;
      srdy_q <= srdy_d; mrdy_q <= mrdy_d; rrdy_q <= rrdy_d; txv_q <= txv_d;
      txd_q <= txd_d; done_q <= done_d; err_q <= err_d; sat_q <= sat_d;
      pos_q <= pos_d; rdcnt_q <= rdcnt_d; isbatt_q <= isbatt_d;
    end
  end

  assign start_ready_o = srdy_q;
  assign meas_ready_o  = mrdy_q;
  assign rd_ready_o    = rrdy_q;
  assign tx_valid_o    = txv_q;
  assign tx_data_o     = txd_q;
  assign done_o        = done_q;
  assign cause_err_o   = err_q;
  assign sat_o         = sat_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_tag_first: assert property (tx_valid_o && pos_q == 12'h000 |->
      tx_data_o == (fmt_d_q ? pbf_pkg::CH_TAG_D : pbf_pkg::CH_TAG_C))
    else $error("first byte is not the format tag");
  chk_cause_byte: assert property (tx_valid_o && pos_q == 12'h001 |->
      tx_data_o == pbf_pkg::CH_ZERO + {5'h0, cause_q})
    else $error("second byte is not the cause digit");
  chk_plus_lead: assert property (tx_valid_o && !fmt_d_q && pos_q == 12'h002 |->
      tx_data_o == pbf_pkg::CH_PLUS)
    else $error("first measurement does not open with plus");
  chk_seq_follows: assert property (ce_i && emit && st_q == pbf_pkg::S_SEQ |->
      tx_data_o == pbf_pkg::CH_PLUS ##1 tx_valid_o && tx_data_o >= pbf_pkg::CH_DEL_SUB)
    else $error("sequence digit not right after plus");
  chk_hold_byte: assert property (tx_valid_o && !tx_ready_i |=>
      tx_valid_o && $stable(tx_data_o))
    else $error("byte changed before acceptance");
  chk_no_del: assert property (tx_valid_o |-> tx_data_o != pbf_pkg::CH_DEL)
    else $error("delete character sent");
  chk_slash_bad: assert property (ce_i && emit && rd_slash |=>
      tx_valid_o && tx_data_o == pbf_pkg::CH_SLASH)
    else $error("bad reading not sent as slash");
  chk_d_length: assert property (tx_valid_o && isbatt_q && fmt_d_q |->
      pos_q == pbf_pkg::D_HDR_BYTES + pbf_pkg::RD_BYTES * {4'h0, rdcnt_q})
    else $error("D report length is wrong");
  chk_period_end: assert property (ce_i && emit && st_q == pbf_pkg::S_BATT && !fmt_d_q |->
      tx_data_o == pbf_pkg::CH_PERIOD)
    else $error("battery byte not preceded by period");
  chk_batt_sat: assert property (ce_i && emit && st_q == pbf_pkg::S_BATT &&
      batt_q > 8'sh1F |=> tx_data_o == 8'h5F && sat_o)
    else $error("battery value not saturated");
endmodule // pbf_cd_framer

// ### dv/pbf_tx_sink.sv
// Model: transmitter byte sink with optional random stalls
`timescale 1ns/100ps
module pbf_tx_sink (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       clr_i,
  input  wire logic       stall_i,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output logic            tx_ready_o
);
  // ---------------------------------------------------------------
  // Capture and hold check
  // ---------------------------------------------------------------
  logic [7:0]  got [0:511];
  int          n      = 0;
  int          viol   = 0;
  logic [15:0] lf_q   = 16'hACE1;
  logic        pend_q = 1'b0;
  logic [7:0]  held_q = 8'h00;

  initial tx_ready_o = 1'b0;

  // Stalls come from a private sequence so they never track the bench values
  always @(posedge clk_i) begin
    lf_q <= {lf_q[14:0], lf_q[15] ^ lf_q[13] ^ lf_q[12] ^ lf_q[10]};
    tx_ready_o <= rst_n_i && (!stall_i || lf_q[0]);
    if (clr_i) begin
      n <= 0;
    end else if (tx_valid_i && tx_ready_o) begin
      got[n] <= tx_data_i;
      n <= n + 1;
    end
    if (pend_q && (tx_valid_i !== 1'b1 || tx_data_i !== held_q)) begin
      viol <= viol + 1;
    end
    pend_q <= rst_n_i && tx_valid_i && !tx_ready_o;
    held_q <= tx_data_i;
  end
endmodule // pbf_tx_sink

// ### dv/pbf_cd_framer_tb.sv
// Testbench: C/D report framer against the byte sink model
`timescale 1ns/100ps
module pbf_cd_framer_tb;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic               clk_i = 1'b0, rst_n_i = 1'b0, start_i = 1'b0, fmt_d_i = 1'b0;
  logic [2:0]         cause_i = 3'h0;
  logic signed [7:0]  batt_i = 8'h00;
  logic [8:0]         sday_i = 9'h000, mday_i = 9'h000;
  logic [10:0]        smin_i = 11'h000, mmin_i = 11'h000;
  logic [1:0]         shift_i = 2'h0;
  logic               mv_i = 1'b0, mlast_i = 1'b0, rv_i = 1'b0, rbad_i = 1'b0, rlast_i = 1'b0;
  logic [5:0]         mseq_i = 6'h00;
  logic [15:0]        mint_i = 16'h0000;
  logic signed [17:0] rval_i = 18'h00000;
  logic               clr_i = 1'b0, stall = 1'b0, ce = 1'b1, tx_ready;
  logic               start_ready_o, meas_ready_o, rd_ready_o, tx_valid_o;
  logic               done_o, cause_err_o, sat_o;
  logic [7:0]         tx_data_o;
  logic [7:0]         exp_q [$];
  logic [31:0]        lf = 32'h9FD3;
  int                 spec_q [$] = '{12345, -12345, 131071, -131072, 63, 2047};
  int                 p10 [0:3] = '{1, 10, 100, 1000};
  int                 err_count = 0, n_tests = 0, n_sat = 0, cyc = 0;

  always #10 clk_i = ~clk_i;

  pbf_cd_framer #(.RD_W(18)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce),
    .start_i(start_i), .fmt_d_i(fmt_d_i), .transmission_cause_code_i(cause_i),
    .batt_i(batt_i), .sched_day_i(sday_i), .sched_min_i(smin_i),
    .decimal_shift_count_i(shift_i), .meas_valid_i(mv_i), .meas_seq_i(mseq_i),
    .meas_day_i(mday_i), .meas_min_i(mmin_i), .meas_interval_i(mint_i),
    .meas_last_i(mlast_i), .rd_valid_i(rv_i), .rd_value_i(rval_i), .rd_bad_i(rbad_i),
    .rd_last_i(rlast_i), .tx_ready_i(tx_ready), .start_ready_o(start_ready_o),
    .meas_ready_o(meas_ready_o), .rd_ready_o(rd_ready_o), .tx_valid_o(tx_valid_o),
    .tx_data_o(tx_data_o), .done_o(done_o), .cause_err_o(cause_err_o), .sat_o(sat_o));

  pbf_tx_sink u_sink (.clk_i(clk_i), .rst_n_i(rst_n_i), .clr_i(clr_i), .stall_i(stall),
    .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .tx_ready_o(tx_ready));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] rnd();
    lf = lf[0] ? ((lf >> 1) ^ 32'h80200003) : (lf >> 1);
    return lf;
  endfunction

  // Expected printable digits, clamped rather than wrapped
  function automatic void put(input int v, input int nd);
    int lim;
    int b;
    lim = 1 << (6 * nd - 1);
    if (v > lim - 1) v = lim - 1;
    if (v < -lim) v = -lim;
    for (int i = nd - 1; i >= 0; i--) begin
      b = ((v >>> (6 * i)) & 63) + 64;
      exp_q.push_back((b == 127) ? 8'h3F : b[7:0]);
    end
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expv);
    n_tests++;
    if (seen !== expv) begin
      err_count++;
      $display("MISMATCH %s expected %0h seen %0h", what, expv, seen);
    end
  endtask

  task automatic conclude();
    check("byte held", u_sink.viol, 0);
    check("saturation seen", n_sat != 0, 1);
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // One full report
  // ---------------------------------------------------------------
  task automatic run(input logic fmt, input logic [2:0] cz, input int nm);
    logic [31:0] r;
    int nr;
    int v;
    int w;
    exp_q.delete();
    r = rnd();
    @(negedge clk_i);
    while (!start_ready_o) @(negedge clk_i);
    fmt_d_i = fmt;
    cause_i = cz;
    batt_i = r[7:0];
    sday_i = r[16:8];
    smin_i = r[27:17];
    shift_i = r[29:28];
    start_i = 1'b1;
    exp_q.push_back(fmt ? pbf_pkg::CH_TAG_D : pbf_pkg::CH_TAG_C);
    exp_q.push_back(pbf_pkg::CH_ZERO + cz);
    if (fmt) put(r[16:8], 2);
    if (fmt) put(r[27:17], 2);
    @(negedge clk_i);
    start_i = 1'b0;
    for (int m = 0; m < nm; m++) begin
      if (!fmt) begin
        r = rnd();
        while (!meas_ready_o) @(negedge clk_i);
        mv_i = 1'b1;
        mseq_i = r[5:0];
        mday_i = r[14:6];
        mmin_i = r[25:15];
        mint_i = r[31:16];
        mlast_i = (m == nm - 1);
        exp_q.push_back(pbf_pkg::CH_PLUS);
        put(r[5:0], 1);
        put(r[14:6], 2);
        put(r[25:15], 2);
        put(r[31:16], 2);
        @(negedge clk_i);
        mv_i = 1'b0;
      end
      nr = 1 + rnd() % 3;
      for (int k = 0; k < nr; k++) begin
        r = rnd();
        v = (spec_q.size() > 0) ? spec_q.pop_front() : $signed(r[17:0]);
        w = v;
        while (!rd_ready_o) @(negedge clk_i);
        rv_i = 1'b1;
        rval_i = w[17:0];
        rbad_i = (r[20:18] == 3'h0);
        rlast_i = (k == nr - 1);
        if (rbad_i) repeat (3) exp_q.push_back(pbf_pkg::CH_SLASH);
        else put(fmt ? v * p10[shift_i] : v, 3);
        @(negedge clk_i);
        rv_i = 1'b0;
      end
    end
    if (!fmt) exp_q.push_back(pbf_pkg::CH_PERIOD);
    put(batt_i, 1);
    v = 0;
    while (done_o !== 1'b1 && v < 4000) begin
      @(negedge clk_i);
      v++;
    end
    check("report done", done_o, 1'b1);
    check("report length", u_sink.n, exp_q.size());
    if (fmt) check("d length", u_sink.n, 7 + 3 * nr);
    for (int i = 0; i < exp_q.size(); i++) check("byte", u_sink.got[i], exp_q[i]);
    clr_i = 1'b1;
    @(negedge clk_i);
    clr_i = 1'b0;
    $display("test report fmt %0d cause %0d ended", fmt, cz);
  endtask

  // A refused start must pulse the error once and send nothing
  task automatic bad(input logic fmt, input logic [2:0] cz);
    logic [2:0] hits;
    hits = 3'h0;
    while (!start_ready_o) @(negedge clk_i);
    fmt_d_i = fmt;
    cause_i = cz;
    start_i = 1'b1;
    @(negedge clk_i);
    start_i = 1'b0;
    repeat (4) begin
      hits = hits + cause_err_o;
      @(negedge clk_i);
    end
    check("cause refused", hits, 3'h1);
    check("no bytes", u_sink.n, 0);
    check("ready kept", start_ready_o, 1'b1);
    $display("test refusal fmt %0d cause %0d ended", fmt, cz);
  endtask

  // Clock enable low must freeze the idle framer against a legal start
  task automatic frozen();
    while (!start_ready_o) @(negedge clk_i);
    ce = 1'b0;
    fmt_d_i = 1'b0;
    cause_i = 3'h1;
    start_i = 1'b1;
    repeat (3) @(negedge clk_i);
    start_i = 1'b0;
    ce = 1'b1;
    @(negedge clk_i);
    check("frozen ready", start_ready_o, 1'b1);
    check("frozen bytes", u_sink.n, 0);
    check("frozen error", cause_err_o, 1'b0);
    $display("test clock enable ended");
  endtask

  // ---------------------------------------------------------------
  // Watchdog and main sequence
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (sat_o === 1'b1) n_sat <= n_sat + 1;
    if (cyc == 60000) begin
      err_count++;
      conclude();
    end
  end

  initial begin
    repeat (2) @(negedge clk_i);
    rst_n_i = 1'b1;
    for (int c = 1; c <= 3; c++) begin
      stall = c[0];
      run(1'b0, c[2:0], c);
    end
    for (int c = 1; c <= 4; c++) begin
      stall = ~c[0];
      run(1'b1, c[2:0], 1);
    end
    frozen();
    bad(1'b0, 3'h0);
    bad(1'b0, 3'h4);
    bad(1'b1, 3'h5);
    bad(1'b1, 3'h0);
    conclude();
  end
endmodule // pbf_cd_framer_tb
